/* File: shared/flash_cfg_regs.vh */
// Constants for the read-path configuration block of the serial flash
// How it works
// - Mode bits 10 skip next word-read opcode
// - Other mode bits restore full opcode decoding
// - Mode reset command clears continuous mode
// - Wrapped read restarts at section start
// - Wrap setting: disable bit plus size bits
// - Parameter command rejected in standard SPI mode
// - Wrap length kept across entry to four-wire mode
// - Reset gives wrap 8 bytes, dummy 2
// - Latency field maps to 10/4/6/8 dummies
// - Double-rate reads: 00 gives 10, else 8
// - Wrap size field gives 8/16/32/64 bytes
// - Wrapped burst reads act like fast read
// - Pattern enable drives pattern in dummy cycles
// - Pattern follows mode bits, mode bits unchanged
// - Training pattern is 00110100
// - Pattern start offset depends on read width
// - Pattern truncated when dummies are short
// - Four-wire entry needs quad enable set
// - Entry keeps write latch, suspend, wrap
// - Exit keeps write latch, suspend, wrap
`ifndef FLASH_CFG_REGS_VH
`define FLASH_CFG_REGS_VH
`define OP_WORD_READ 8'hE7
`define OP_SET_WRAP 8'h77
`define OP_SET_PARAM 8'hC0
`define OP_WRAP_READ 8'h0C
`define OP_WRAP_READ_DTR 8'h0E
`define OP_FAST_READ 8'h0B
`define OP_QIO_READ 8'hEB
`define OP_SFDP_READ 8'h5A
`define OP_DTR_FAST 8'h0D
`define OP_DTR_QIO 8'hED
`define OP_ENTER_QUAD 8'h38
`define OP_EXIT_QUAD 8'hFF
`define OP_MODE_RESET 8'hFF
`define CONT_SEL_MATCH 2'h2
`define WRAP_SET_RESET 3'h1
`define PARAM_RESET 8'h00
`define DUMMY_DEFAULT 4'h2
`define TRAIN_PATTERN 8'h34
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

/* File: src/byte_fifo.v */
// Small flip-flop FIFO for read-data bytes
`timescale 1ns/1ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_sys,
   input wire rst_b,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   input wire flush
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   integer i;
   localparam [AW:0] FULL_COUNT = DEPTH;
   assign in_ready = (cnt_reg != FULL_COUNT);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem_reg[i] <= {WIDTH{1'b0}};
      end else if (flush) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_reg[wr_reg] <= in_data;
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop)
            rd_reg <= rd_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule // byte_fifo

/* File: src/flash_read_mode_config.v */
// Read-path configuration and command interpreter for the quad flash
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module flash_read_mode_config (
   input wire clk_sys,
   input wire rst_b,
   input wire soft_reset,
   input wire frame_start,
   input wire frame_end,
   input wire cmd_valid,
   input wire [7:0] cmd_byte,
   input wire [23:0] cmd_addr,
   input wire [7:0] mode_byte,
   input wire param_valid,
   input wire [7:0] param_byte,
   input wire quad_enable_bit,
   input wire training_pattern_enable,
   input wire dtr_read,
   input wire [1:0] io_width,
   input wire dummy_count_bit,
   input wire array_valid,
   output wire array_ready,
   input wire [7:0] array_data,
   output wire data_valid,
   input wire data_ready,
   output wire [7:0] data_out,
   output reg [23:0] fetch_addr,
   output reg four_wire_command_mode,
   output reg continuous_mode,
   output reg [2:0] wrap_setting_bits,
   output reg [5:0] latency_dummy,
   output reg [6:0] wrap_bytes,
   output reg wrap_active,
   output reg [3:0] train_start,
   output reg [3:0] train_bits,
   output reg [7:0] train_pattern,
   output reg cmd_rejected
);
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_PARAM = 2'h2;
   localparam ST_WRAPSET = 2'h3;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [7:0] param_reg;
   reg skip_op_reg;
   reg [7:0] read_op_reg;
   reg read_wrap_reg;
   wire [1:0] latency_field;
   wire [1:0] wrap_size_field;
   wire [1:0] continuous_mode_select_bits;
   wire wrap_disable_bit;
   wire [1:0] wrap_size_bits;
   wire is_read_op;
   wire is_dtr_op;
   wire push_ok;
   wire [5:0] dummy_now;
   wire [7:0] eff_op;
   wire fifo_in_ready;

   assign latency_field = param_reg[5:4];
   assign wrap_size_field = param_reg[1:0];
   assign wrap_disable_bit = wrap_setting_bits[0];
   assign wrap_size_bits = wrap_setting_bits[2:1];
   assign continuous_mode_select_bits = mode_byte[5:4];

   // Section length in bytes from a two-bit size code
   function [6:0] wrap_len;
      input [1:0] code;
      begin
         case (code)
            2'h0: wrap_len = 7'h08;
            2'h1: wrap_len = 7'h10;
            2'h2: wrap_len = 7'h20;
            default: wrap_len = 7'h40;
         endcase
      end
   endfunction

   // Next address inside an aligned wrap section
   function [23:0] wrap_inc;
      input [23:0] a;
      input [6:0] len;
      reg [23:0] m;
      begin
         m = {17'h00000, len - 7'h01};
         wrap_inc = (a & ~m) | ((a + 24'h000001) & m);
      end
   endfunction

   // A frame that skips the opcode reuses the word read; FFh still resets
   assign eff_op = (skip_op_reg && cmd_byte != `OP_MODE_RESET) ?
      `OP_WORD_READ : cmd_byte;
   assign is_dtr_op = (eff_op == `OP_DTR_FAST) || (eff_op == `OP_DTR_QIO) ||
      (eff_op == `OP_WRAP_READ_DTR);
   assign is_read_op = (eff_op == `OP_WORD_READ) ||
      (eff_op == `OP_FAST_READ) || (eff_op == `OP_QIO_READ) ||
      (eff_op == `OP_SFDP_READ) || (eff_op == `OP_WRAP_READ) || is_dtr_op;

   // Dummy count for the current command
   assign dummy_now = !four_wire_command_mode ?
      (dummy_count_bit ? 6'h04 : {2'h0, `DUMMY_DEFAULT}) :
      is_dtr_op ? ((latency_field == 2'h0) ? 6'h0A : 6'h08) :
      (latency_field == 2'h0) ? 6'h0A :
      (latency_field == 2'h1) ? 6'h04 :
      (latency_field == 2'h2) ? 6'h06 : 6'h08;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_valid) begin
               if (is_read_op)
                  state_next = ST_READ;
               else if (eff_op == `OP_SET_PARAM && four_wire_command_mode)
                  state_next = ST_PARAM;
               else if (eff_op == `OP_SET_WRAP && !four_wire_command_mode)
                  state_next = ST_WRAPSET;
            end
         end
         ST_READ: if (frame_end) state_next = ST_IDLE;
         ST_PARAM: if (param_valid || frame_end) state_next = ST_IDLE;
         ST_WRAPSET: if (param_valid || frame_end) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   assign push_ok = (state_reg == ST_READ) && !frame_end;
   assign array_ready = push_ok & fifo_in_ready;

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(array_valid & push_ok),
      .in_ready(fifo_in_ready),
      .in_data(array_data),
      .out_valid(data_valid),
      .out_ready(data_ready),
      .out_data(data_out),
      .flush(frame_end)
   );

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         param_reg <= `PARAM_RESET;
         wrap_setting_bits <= `WRAP_SET_RESET;
         four_wire_command_mode <= 1'b0;
         skip_op_reg <= 1'b0;
         continuous_mode <= 1'b0;
         read_op_reg <= 8'h00;
         read_wrap_reg <= 1'b0;
         fetch_addr <= 24'h000000;
         latency_dummy <= {2'h0, `DUMMY_DEFAULT};
         wrap_bytes <= 7'h08;
         wrap_active <= 1'b0;
         train_start <= 4'h0;
         train_bits <= 4'h0;
         train_pattern <= 8'h00;
         cmd_rejected <= 1'b0;
      end else if (soft_reset) begin
         // Reset instruction restores wrap 8 bytes and dummy 2
         state_reg <= ST_IDLE;
         param_reg <= `PARAM_RESET;
         wrap_setting_bits <= `WRAP_SET_RESET;
         four_wire_command_mode <= 1'b0;
         skip_op_reg <= 1'b0;
         continuous_mode <= 1'b0;
         latency_dummy <= {2'h0, `DUMMY_DEFAULT};
         wrap_bytes <= 7'h08;
         wrap_active <= 1'b0;
         train_bits <= 4'h0;
         cmd_rejected <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_rejected <= 1'b0;
         if (state_reg == ST_IDLE && cmd_valid) begin
            read_op_reg <= eff_op;
            fetch_addr <= cmd_addr;
            latency_dummy <= dummy_now;
            if (skip_op_reg && cmd_byte == `OP_MODE_RESET && !is_read_op) begin
               skip_op_reg <= 1'b0;
               continuous_mode <= 1'b0;
            end
            if (is_read_op) begin
               // Mode bits decide opcode skipping on the next frame
               if (eff_op == `OP_WORD_READ || eff_op == `OP_QIO_READ ||
                  eff_op == `OP_DTR_QIO) begin
                  skip_op_reg <= (continuous_mode_select_bits ==
                     `CONT_SEL_MATCH) && (eff_op == `OP_WORD_READ);
                  continuous_mode <= (continuous_mode_select_bits ==
                     `CONT_SEL_MATCH);
               end
               if (four_wire_command_mode) begin
                  read_wrap_reg <= (eff_op == `OP_WRAP_READ) ||
                     (eff_op == `OP_WRAP_READ_DTR);
                  wrap_bytes <= wrap_len(wrap_size_field);
                  wrap_active <= (eff_op == `OP_WRAP_READ) ||
                     (eff_op == `OP_WRAP_READ_DTR);
               end else begin
                  read_wrap_reg <= !wrap_disable_bit;
                  wrap_bytes <= wrap_len(wrap_size_bits);
                  wrap_active <= !wrap_disable_bit;
               end
               // Pattern sits after mode bits; cut when dummies short
               if (training_pattern_enable) begin
                  train_pattern <= `TRAIN_PATTERN;
                  train_start <= (io_width == 2'h2) ? 4'h2 :
                     (io_width == 2'h1) ? 4'h4 :
                     dtr_read ? 4'h2 : 4'h0;
                  train_bits <= (dummy_now >= 6'h08) ? 4'h8 :
                     dummy_now[3:0];
               end else begin
                  train_pattern <= 8'h00;
                  train_start <= 4'h0;
                  train_bits <= 4'h0;
               end
            end else begin
               if (!skip_op_reg || cmd_byte != `OP_MODE_RESET) begin
                  skip_op_reg <= 1'b0;
                  continuous_mode <= 1'b0;
               end
               if (eff_op == `OP_SET_PARAM && !four_wire_command_mode)
                  cmd_rejected <= 1'b1;
               // Only the mode bit moves; latch, suspend, wrap untouched
               if (eff_op == `OP_ENTER_QUAD && !four_wire_command_mode &&
                  !skip_op_reg) begin
                  if (quad_enable_bit)
                     four_wire_command_mode <= 1'b1;
                  else
                     cmd_rejected <= 1'b1;
               end
               if (eff_op == `OP_EXIT_QUAD && four_wire_command_mode &&
                  !skip_op_reg)
                  four_wire_command_mode <= 1'b0;
            end
         end
         if (state_reg == ST_PARAM && param_valid) begin
            param_reg <= param_byte;
            wrap_bytes <= wrap_len(param_byte[1:0]);
         end
         // Wrap size also goes to the four-wire field, so it survives entry to four-wire mode
         if (state_reg == ST_WRAPSET && param_valid) begin
            wrap_setting_bits <= param_byte[6:4];
            param_reg[1:0] <= param_byte[6:5];
            wrap_bytes <= wrap_len(param_byte[6:5]);
         end
         // Address walks on each accepted array byte
         if (array_valid && array_ready) begin
            if (read_wrap_reg)
               fetch_addr <= wrap_inc(fetch_addr, wrap_bytes);
            else
               fetch_addr <= fetch_addr + 24'h000001;
         end
         if (frame_end)
            wrap_active <= 1'b0;
      end
   end
endmodule // flash_read_mode_config

/* File: verif/flash_read_mode_config_asserts.sv */
// Port-level assertions for the read-mode configuration block
`timescale 1ns/1ps
module flash_read_mode_config_asserts (
   input wire clk_sys,
   input wire rst_b,
   input wire soft_reset,
   input wire cmd_valid,
   input wire [7:0] cmd_byte,
   input wire [7:0] mode_byte,
   input wire quad_enable_bit,
   input wire four_wire_command_mode,
   input wire continuous_mode,
   input wire [2:0] wrap_setting_bits,
   input wire [5:0] latency_dummy,
   input wire [6:0] wrap_bytes,
   input wire [3:0] train_bits,
   input wire [7:0] train_pattern,
   input wire cmd_rejected
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Plain SPI command, no armed continuous read
   sequence spi_cmd;
      cmd_valid && !continuous_mode && !four_wire_command_mode;
   endsequence
   reset_defaults_a: assert property (!$past(rst_b) |->
      wrap_setting_bits == 3'h1 && latency_dummy == 6'h02 &&
      wrap_bytes == 7'h08) else $error("bad defaults after reset");
   soft_defaults_a: assert property (soft_reset |=>
      wrap_setting_bits == 3'h1 && wrap_bytes == 7'h08)
      else $error("bad defaults after soft reset");
   cont_arm_a: assert property (spi_cmd ##0 cmd_byte == 8'hE7 &&
      quad_enable_bit && mode_byte[5:4] == 2'h2 |=> continuous_mode)
      else $error("continuous read not armed");
   cont_leave_a: assert property (cmd_valid && continuous_mode &&
      cmd_byte != 8'hFF && mode_byte[5:4] != 2'h2 |=> !continuous_mode)
      else $error("continuous read not left");
   mode_reset_a: assert property (cmd_valid && continuous_mode &&
      cmd_byte == 8'hFF |=> !continuous_mode) else $error("no mode reset");
   param_reject_a: assert property (spi_cmd ##0
      cmd_byte == 8'hC0 |=> cmd_rejected ##1 !cmd_rejected)
      else $error("parameter command not rejected");
   entry_refused_a: assert property (spi_cmd ##0
      cmd_byte == 8'h38 && !quad_enable_bit |=> cmd_rejected &&
      !four_wire_command_mode) else $error("entry not refused");
   entry_keeps_a: assert property (spi_cmd ##0
      cmd_byte == 8'h38 && quad_enable_bit |=> four_wire_command_mode &&
      $stable(wrap_setting_bits)) else $error("bad four-wire entry");
   exit_keeps_a: assert property (cmd_valid && !continuous_mode &&
      four_wire_command_mode && cmd_byte == 8'hFF |=> !four_wire_command_mode
      && $stable(wrap_setting_bits)) else $error("bad four-wire exit");
   pattern_value_a: assert property (train_pattern != 8'h00 |->
      train_pattern == 8'h34) else $error("wrong training pattern");
   pattern_cut_a: assert property (train_bits <= 4'h8)
      else $error("training pattern longer than eight bits");
endmodule // flash_read_mode_config_asserts

bind flash_read_mode_config flash_read_mode_config_asserts u_chk (
   .clk_sys, .rst_b, .soft_reset, .cmd_valid, .cmd_byte, .mode_byte,
   .quad_enable_bit, .four_wire_command_mode, .continuous_mode,
   .wrap_setting_bits, .latency_dummy, .wrap_bytes, .train_bits,
   .train_pattern, .cmd_rejected);

/* File: verif/array_source.sv */
// Behavioural array-side byte source feeding the read FIFO
`timescale 1ns/1ps
module array_source (
   input wire clk_sys,
   input wire rst_b,
   input wire go,
   input wire array_ready,
   output reg array_valid,
   output reg [7:0] array_data
);
   // Idle bus toggles every cycle so a stale byte never looks valid
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         array_valid <= 1'b0;
         array_data <= 8'h5A;
      end else if (!array_valid || array_ready) begin
         array_valid <= go;
         array_data <= go ? array_data + 8'h13 : ~array_data;
      end
   end
endmodule // array_source

/* File: verif/tb_flash_read_mode_config.sv */
// Self-checking bench for the read-mode configuration block
`timescale 1ns/1ps
module tb_flash_read_mode_config;
   reg clk_sys, rst_b, soft_reset, frame_start, frame_end, cmd_valid, go;
   reg param_valid, quad_enable_bit, training_pattern_enable, dtr_read;
   reg data_ready, mon, dummy_count_bit;
   reg [1:0] io_width;
   reg [7:0] cmd_byte, mode_byte, param_byte;
   reg [23:0] cmd_addr, start, lmask;
   wire array_ready, array_valid, data_valid, four_wire_command_mode;
   wire continuous_mode, wrap_active, cmd_rejected;
   wire [7:0] array_data, data_out, train_pattern;
   wire [23:0] fetch_addr;
   wire [2:0] wrap_setting_bits;
   wire [5:0] latency_dummy;
   wire [6:0] wrap_bytes;
   wire [3:0] train_start, train_bits;
   int bad_count, n_compared, ai, k, p, d, e;
   logic [7:0] q[$];

   flash_read_mode_config u_dut (.clk_sys, .rst_b, .soft_reset,
      .frame_start, .frame_end, .cmd_valid, .cmd_byte, .cmd_addr,
      .mode_byte, .param_valid, .param_byte, .quad_enable_bit,
      .training_pattern_enable, .dtr_read, .io_width,
      .dummy_count_bit, .array_valid, .array_ready, .array_data,
      .data_valid, .data_ready, .data_out, .fetch_addr,
      .four_wire_command_mode, .continuous_mode, .wrap_setting_bits,
      .latency_dummy, .wrap_bytes, .wrap_active, .train_start,
      .train_bits, .train_pattern, .cmd_rejected);
   array_source u_src (.clk_sys, .rst_b, .go, .array_ready, .array_valid,
      .array_data);

   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [23:0] got, input [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task lim;
      if (k >= 400) begin
         bad_count++;
         complete_run;
      end
   endtask
   task step;
      @(posedge clk_sys);
      #1;
   endtask
   task cmd(input [7:0] op, input [23:0] a, input [7:0] m);
      @(posedge clk_sys);
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
      cmd_valid <= 1'b1;
      cmd_byte <= op;
      cmd_addr <= a;
      mode_byte <= m;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
   task par(input [7:0] b);
      param_valid <= 1'b1;
      param_byte <= b;
      @(posedge clk_sys);
      param_valid <= 1'b0;
   endtask
   task fin;
      frame_end <= 1'b1;
      @(posedge clk_sys);
      frame_end <= 1'b0;
      step;
   endtask
   // Fill FIFO with the consumer stalled, then drain it
   task stream(input [23:0] a, input [23:0] len, input int n);
      start = a;
      lmask = len - 24'h1;
      ai = 0;
      q.delete();
      mon = 1'b1;
      @(posedge clk_sys);
      go <= 1'b1;
      data_ready <= 1'b0;
      for (k = 0; k < 400 && ai < 8; k++) step;
      lim;
      repeat (3) step;
      chk(array_ready, 24'h0);
      @(posedge clk_sys);
      data_ready <= 1'b1;
      for (k = 0; k < 400 && ai < n; k++) step;
      lim;
      @(posedge clk_sys);
      go <= 1'b0;
      for (k = 0; k < 400 && (q.size() > 0 || array_valid); k++) step;
      lim;
      chk(wrap_active, 24'h1);
      mon = 1'b0;
      fin;
   endtask

   always @(posedge clk_sys) begin
      if (mon && array_valid && array_ready) begin
         chk(fetch_addr, (start & ~lmask) | ((start + ai) & lmask));
         q.push_back(array_data);
         ai++;
      end
      if (mon && data_valid && data_ready)
         chk(data_out, q.pop_front());
   end

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      {rst_b, soft_reset, frame_start, frame_end, cmd_valid, go} = 6'h00;
      {param_valid, quad_enable_bit, dtr_read, data_ready, mon} = 5'h00;
      training_pattern_enable = 1'b0;
      dummy_count_bit = 1'b0;
      io_width = 2'h2;
      {cmd_byte, mode_byte, param_byte, cmd_addr} = 48'h0;
      bad_count = 0;
      n_compared = 0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      step;
      chk(wrap_setting_bits, 24'h1);
      chk(latency_dummy, 24'h2);
      chk(wrap_bytes, 24'h8);
      cmd(8'hC0, 24'h0, 8'h0);
      fin;
      chk(latency_dummy, 24'h2);
      @(posedge clk_sys);
      dummy_count_bit <= 1'b1;
      cmd(8'h0B, 24'h0, 8'h0);
      fin;
      chk(latency_dummy, 24'h4);
      @(posedge clk_sys);
      dummy_count_bit <= 1'b0;
      cmd(8'h38, 24'h0, 8'h0);
      fin;
      chk(four_wire_command_mode, 24'h0);
      @(posedge clk_sys);
      quad_enable_bit <= 1'b1;
      for (p = 3; p >= 0; p--) begin
         cmd(8'h77, 24'h0, 8'h0);
         par({1'b0, p[1:0], 5'h00});
         fin;
         chk(wrap_setting_bits, {p[1:0], 1'b0});
         chk(wrap_bytes, 24'h8 << p);
      end
      cmd(8'hE7, 24'h000105, 8'h20);
      stream(24'h000105, 24'h8, 12);
      chk(continuous_mode, 24'h1);
      cmd(8'h00, 24'h000206, 8'h00);
      stream(24'h000206, 24'h8, 4);
      chk(continuous_mode, 24'h0);
      cmd(8'hE7, 24'h000300, 8'h20);
      fin;
      cmd(8'hFF, 24'h0, 8'h0);
      fin;
      chk(continuous_mode, 24'h0);
      cmd(8'h38, 24'h0, 8'h0);
      fin;
      chk(four_wire_command_mode, 24'h1);
      chk(wrap_setting_bits, 24'h0);
      chk(wrap_bytes, 24'h8);
      @(posedge clk_sys);
      training_pattern_enable <= 1'b1;
      for (p = 0; p < 4; p++) begin
         for (d = 0; d < 2; d++) begin
            @(posedge clk_sys);
            dtr_read <= d[0];
            io_width <= d ? 2'h1 : 2'h2;
            cmd(8'hC0, 24'h0, 8'h0);
            par({2'h0, p[1:0], 2'h0, p[1:0]});
            fin;
            chk(wrap_bytes, 24'h8 << p);
            cmd(d ? 8'h0D : 8'h0B, 24'h0, 8'h0);
            step;
            e = d ? (p ? 8 : 10) : (p == 1 ? 4 : p == 2 ? 6 : p == 3 ? 8 : 10);
            chk(latency_dummy, e);
            chk(train_pattern, 24'h34);
            chk(train_start, d ? 24'h4 : 24'h2);
            chk(train_bits, e >= 8 ? 8 : e);
            fin;
         end
      end
      cmd(8'hC0, 24'h0, 8'h0);
      par(8'h01);
      fin;
      cmd(8'h0C, 24'h00011E, 8'h0);
      stream(24'h00011E, 24'h10, 20);
      cmd(8'hFF, 24'h0, 8'h0);
      fin;
      chk(four_wire_command_mode, 24'h0);
      chk(wrap_setting_bits, 24'h0);
      @(posedge clk_sys);
      soft_reset <= 1'b1;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      step;
      chk(wrap_setting_bits, 24'h1);
      chk(latency_dummy, 24'h2);
      complete_run;
   end
endmodule // tb_flash_read_mode_config
